// [hw/smc_ctrl.sv]
// sleep mode and clock gating controller with apb register slave
`include "smc_regs.svh"

// Function
// - sleep only when enable bit is set and sleep instruction executes
// - on interrupt wake, hold cpu four cycles after start-up, then resume
// - register file and data memory are kept unchanged across sleep
// - reset during sleep wakes the device and restarts at the reset vector
// - power-down and power-save wake waits the fuse-selected time-out
// - mode 000 is idle: only cpu and flash clocks stop
// - idle wakes on any enabled interrupt source
// - mode 010 is power-down: oscillator and all generated clocks stop
// - power-down wakes only on listed external and watchdog events
// - outside idle, external interrupt pins wake only as held levels
// - mode 011 is power-save: power-down plus running timer2
// - timer2 wakes power-save only with its mask bit and global enable
// - power-save stops timer oscillator or sync source that timer2 lacks
// - mode 110 is standby: power-down with oscillator on, six-cycle wake
// - mode 111 is extended standby: power-save with oscillator, six cycles
// - timer oscillator kept only while timer2 is async; async domain too, but only in mode 111
// - setting a gate bit stops that peripheral clock and locks its regs
// - clearing a gate bit restarts the clock with state preserved
// - control register: mode in bits 3..1, enable in bit 0; some reserved
module smc_ctrl #(
  parameter logic [19:0] TOUT_SHORT = 20'h04000,
  parameter logic [19:0] TOUT_LONG  = 20'h10000
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_nrst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_sleep_instr,
  input  wire logic        i_gie,
  input  wire logic [1:0]  i_timer2_irq_mask,
  input  wire logic        i_t2_async,
  input  wire logic        i_t2_running,
  input  wire logic [3:0]  i_clock_source_fuses,
  input  wire logic [3:0]  i_ext_irq_en,
  input  wire logic [3:0]  i_ext_irq_flag,
  input  wire logic [3:0]  i_ext_irq_pins_n,
  input  wire logic        i_wake_comm,
  input  wire logic        i_wake_card,
  input  wire logic        i_wake_pcint,
  input  wire logic        i_wake_kbd,
  input  wire logic        i_wake_wdt,
  input  wire logic        i_wake_t2_ovf,
  input  wire logic        i_wake_t2_cmp,
  input  wire logic        i_wake_spm_ee,
  input  wire logic        i_wake_other,
  input  wire logic        i_ext_reset,
  output logic             o_core_clk_en,
  output logic             o_prog_mem_clk_en,
  output logic             o_io_clk_en,
  output logic             o_hs_clk_en,
  output logic             o_async_clk_en,
  output logic             o_main_osc_en,
  output logic             o_timer_osc_en,
  output logic             o_t2_sync_clk_en,
  output logic      [15:0] o_periph_clk_en,
  output logic      [15:0] o_periph_lock,
  output logic             o_mem_write_block,
  output logic             o_irq_resume,
  output logic             o_core_restart,
  output logic             o_sleeping
);
  typedef struct packed {
    smc_pkg::smc_state_t state;
    logic [2:0]          mode_sel;
    logic                se;
    logic [2:0]          mode_lat;
    logic [7:0]          gate0;
    logic [7:0]          gate1;
    logic                by_reset;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    logic                core_en;
    logic                mem_en;
    logic                io_en;
    logic                hs_en;
    logic                asy_en;
    logic                osc_en;
    logic                tosc_en;
    logic                t2s_en;
    logic [15:0]         pclk_en;
    logic [15:0]         plock;
    logic                mem_blk;
    logic                resume;
    logic                restart;
    logic                sleeping;
    // cycles spent in start and hold, read only by the wake bound check
    logic [20:0]         wake_age;
  } smc_st_t;

  smc_st_t     st;
  smc_st_t     next_st;
  logic [13:0] sync_w;
  logic [3:0]  pins_n_s;
  logic        comm_s;
  logic        card_s;
  logic        pcint_s;
  logic        kbd_s;
  logic        wdt_s;
  logic        t2ovf_s;
  logic        t2cmp_s;
  logic        spm_s;
  logic        other_s;
  logic        rst_s;
  logic        cnt_load;
  logic [19:0] cnt_val;
  logic        cnt_done;
  logic [15:0] pen_w;
  logic [15:0] gate_all;

  // every pin or foreign-domain event is synchronised before use
  smc_sync #(
    .W (14)
  ) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_async   ({i_ext_irq_pins_n, i_wake_comm, i_wake_card, i_wake_pcint,
                 i_wake_kbd, i_wake_wdt, i_wake_t2_ovf, i_wake_t2_cmp,
                 i_wake_spm_ee, i_wake_other, i_ext_reset}),
    .o_sync    (sync_w)
  );

  assign {pins_n_s, comm_s, card_s, pcint_s, kbd_s, wdt_s,
          t2ovf_s, t2cmp_s, spm_s, other_s, rst_s} = sync_w;

  smc_wake_cnt #(
    .W (`SMC_CNT_W)
  ) u_cnt (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_load    (cnt_load),
    .i_count   (cnt_val),
    .o_done    (cnt_done)
  );

  // gate takes effect on the enables one cycle after the register write
  assign gate_all = {st.gate1, st.gate0};
  for (genvar g = 0; g < 16; g++) begin : g_periph
    assign pen_w[g] = ~gate_all[g] & st.io_en;
  end

  logic       acc;
  logic [7:0] idx;
  logic       hit;
  logic       wr;
  logic       legal;
  logic       ext_lvl;
  logic       t2_ev;
  logic       wake;
  logic       t2_sync;
  logic [2:0] m;

  always_comb begin
    next_st         = st;
    cnt_load        = 1'b0;
    cnt_val         = `SMC_HOLD_CYC;
    next_st.resume  = 1'b0;
    next_st.restart = 1'b0;
    acc   = i_psel & i_penable;
    idx   = i_paddr[9:2];
    hit   = (i_paddr[11:10] == 2'h0) &&
            ((idx == `SMC_IDX_CTRL) || (idx == `SMC_IDX_GATE0) ||
             (idx == `SMC_IDX_GATE1) || (idx == `SMC_IDX_STATUS));
    wr    = acc & st.pready & i_pwrite & hit;
    // one wait state: pready rises in the cycle after penable
    next_st.pready  = acc & ~st.pready;
    next_st.pslverr = acc & ~st.pready & ~hit;
    if (acc && !st.pready) begin
      case (idx)
        `SMC_IDX_CTRL:   next_st.prdata = {28'h0, st.mode_sel, st.se};
        `SMC_IDX_GATE0:  next_st.prdata = {24'h0, st.gate0};
        `SMC_IDX_GATE1:  next_st.prdata = {24'h0, st.gate1};
        `SMC_IDX_STATUS: next_st.prdata = {26'h0, st.by_reset, st.mode_lat,
                                           st.state};
        default:         next_st.prdata = 32'h0;
      endcase
    end
    if (wr) begin
      unique case (idx)
        `SMC_IDX_CTRL: begin
          next_st.se = i_pwdata[`SMC_CTRL_SE_BIT];
          next_st.mode_sel =
            i_pwdata[`SMC_CTRL_MODE_MSB:`SMC_CTRL_MODE_LSB];
        end
        `SMC_IDX_GATE0:  next_st.gate0 = i_pwdata[7:0] & `SMC_GATE0_MASK;
        `SMC_IDX_GATE1:  next_st.gate1 = i_pwdata[7:0] & `SMC_GATE1_MASK;
        `SMC_IDX_STATUS: next_st.gate0 = st.gate0;
      endcase
    end

    // reserved mode codes make the sleep instruction a no-op
    legal = (st.mode_sel == smc_pkg::SMC_IDLE)  ||
            (st.mode_sel == smc_pkg::SMC_PDOWN) ||
            (st.mode_sel == smc_pkg::SMC_PSAVE) ||
            (st.mode_sel == smc_pkg::SMC_STBY)  ||
            (st.mode_sel == smc_pkg::SMC_XSTBY);
    ext_lvl = |(i_ext_irq_en & ~pins_n_s);
    t2_ev   = i_gie & ((i_timer2_irq_mask[0] & t2ovf_s) |
                       (i_timer2_irq_mask[1] & t2cmp_s));
    wake    = ext_lvl | comm_s | card_s | pcint_s | kbd_s | wdt_s;
    if (st.mode_lat == smc_pkg::SMC_IDLE) begin
      wake = wake | (|(i_ext_irq_en & i_ext_irq_flag)) | t2_ev |
             spm_s | other_s;
    end else if ((st.mode_lat == smc_pkg::SMC_PSAVE) ||
                 (st.mode_lat == smc_pkg::SMC_XSTBY)) begin
      wake = wake | t2_ev;
    end

    unique case (st.state)
      smc_pkg::SMC_RUN: begin
        if (i_sleep_instr && st.se && legal) begin
          next_st.state    = smc_pkg::SMC_ASLEEP;
          next_st.mode_lat = st.mode_sel;
          next_st.by_reset = 1'b0;
        end
      end
      smc_pkg::SMC_ASLEEP: begin
        if (rst_s || wake) begin
          next_st.by_reset = rst_s;
          cnt_load         = 1'b1;
          if (st.mode_lat == smc_pkg::SMC_IDLE) begin
            next_st.state = smc_pkg::SMC_HOLD;
          end else begin
            next_st.state = smc_pkg::SMC_START;
            if ((st.mode_lat == smc_pkg::SMC_STBY) ||
                (st.mode_lat == smc_pkg::SMC_XSTBY)) begin
              cnt_val = `SMC_STBY_CYC;
            end else begin
              cnt_val = i_clock_source_fuses[0] ? TOUT_LONG
                                                : TOUT_SHORT;
            end
          end
        end
      end
      smc_pkg::SMC_START: begin
        if (rst_s) begin
          next_st.by_reset = 1'b1;
        end
        if (cnt_done) begin
          next_st.state = smc_pkg::SMC_HOLD;
          cnt_load      = 1'b1;
        end
      end
      smc_pkg::SMC_HOLD: begin
        if (rst_s) begin
          next_st.by_reset = 1'b1;
        end
        if (cnt_done) begin
          next_st.state   = smc_pkg::SMC_RUN;
          next_st.resume  = ~(st.by_reset | rst_s);
          next_st.restart = st.by_reset | rst_s;
        end
      end
    endcase

    // enables derive from the next state so they switch on a flop edge
    m       = next_st.mode_lat;
    t2_sync = ~i_t2_async & i_t2_running;
    next_st.core_en = (next_st.state == smc_pkg::SMC_RUN);
    next_st.mem_en  = (next_st.state == smc_pkg::SMC_RUN);
    next_st.io_en   = 1'b1;
    next_st.hs_en   = 1'b1;
    next_st.asy_en  = 1'b1;
    next_st.osc_en  = 1'b1;
    next_st.tosc_en = i_t2_async;
    next_st.t2s_en  = 1'b1;
    if ((next_st.state == smc_pkg::SMC_ASLEEP) ||
        (next_st.state == smc_pkg::SMC_START)) begin
      if (m != smc_pkg::SMC_IDLE) begin
        next_st.io_en = 1'b0;
        next_st.hs_en = 1'b0;
      end
      if ((m == smc_pkg::SMC_PDOWN) || (m == smc_pkg::SMC_STBY)) begin
        next_st.asy_en  = 1'b0;
        next_st.tosc_en = 1'b0;
        next_st.t2s_en  = 1'b0;
        next_st.osc_en  = (m == smc_pkg::SMC_STBY);
      end else if (m == smc_pkg::SMC_PSAVE) begin
        next_st.t2s_en = t2_sync;
        next_st.osc_en = t2_sync;
      end else if (m == smc_pkg::SMC_XSTBY) begin
        next_st.asy_en = i_t2_async;
        next_st.t2s_en = t2_sync;
      end
      // the oscillator restarts for the stabilisation wait
      if (next_st.state == smc_pkg::SMC_START) begin
        next_st.osc_en = 1'b1;
      end
    end
    next_st.pclk_en  = pen_w;
    next_st.plock    = gate_all;
    next_st.mem_blk  = (next_st.state != smc_pkg::SMC_RUN);
    next_st.sleeping = (next_st.state != smc_pkg::SMC_RUN);
    next_st.wake_age = ((next_st.state == smc_pkg::SMC_START) ||
                        (next_st.state == smc_pkg::SMC_HOLD)) ?
                       st.wake_age + 21'h000001 : 21'h000000;
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      st          <= '0;
      st.state    <= smc_pkg::SMC_RUN;
      {st.mode_sel, st.se} <= `SMC_CTRL_RST;
      st.gate0    <= `SMC_GATE_RST;
      st.gate1    <= `SMC_GATE_RST;
      st.core_en  <= 1'b1;
      st.mem_en   <= 1'b1;
      st.io_en    <= 1'b1;
      st.hs_en    <= 1'b1;
      st.asy_en   <= 1'b1;
      st.osc_en   <= 1'b1;
      st.t2s_en   <= 1'b1;
      st.pclk_en  <= 16'hffff;
    end else begin
      st <= next_st;
    end
  end

  assign o_prdata          = st.prdata;
  assign o_pready          = st.pready;
  assign o_pslverr         = st.pslverr;
  assign o_core_clk_en     = st.core_en;
  assign o_prog_mem_clk_en = st.mem_en;
  assign o_io_clk_en       = st.io_en;
  assign o_hs_clk_en       = st.hs_en;
  assign o_async_clk_en    = st.asy_en;
  assign o_main_osc_en     = st.osc_en;
  assign o_timer_osc_en    = st.tosc_en;
  assign o_t2_sync_clk_en  = st.t2s_en;
  assign o_periph_clk_en   = st.pclk_en;
  assign o_periph_lock     = st.plock;
  assign o_mem_write_block = st.mem_blk;
  assign o_irq_resume      = st.resume;
  assign o_core_restart    = st.restart;
  assign o_sleeping        = st.sleeping;

  // longest start-up plus the hold phase, with room for the six-cycle wake
  localparam logic [20:0] AGE_MAX =
    21'(TOUT_LONG > TOUT_SHORT ? TOUT_LONG : TOUT_SHORT) + 21'h00000a;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);

  sequence s_hold4;
    (st.state == smc_pkg::SMC_HOLD) [*4] ##1 (st.state == smc_pkg::SMC_RUN);
  endsequence
  sequence s_stby6;
    (st.state == smc_pkg::SMC_START) [*6] ##1
    (st.state == smc_pkg::SMC_HOLD);
  endsequence

  property p_enter_se;
    (st.state == smc_pkg::SMC_RUN) ##1 (st.state == smc_pkg::SMC_ASLEEP)
    |-> $past(i_sleep_instr) && $past(st.se);
  endproperty
  a_enter_se: assert property (p_enter_se)
    else $error("sleep entered without enable bit");

  property p_hold;
    $changed(st.state) && (st.state == smc_pkg::SMC_HOLD) && !rst_s
    |-> s_hold4 ##0 (o_irq_resume || o_core_restart);
  endproperty
  a_hold: assert property (p_hold)
    else $error("cpu hold not four cycles");

  property p_mem;
    (st.state != smc_pkg::SMC_RUN) |-> o_mem_write_block && !o_core_clk_en;
  endproperty
  a_mem: assert property (p_mem)
    else $error("memory writable during sleep");

  property p_rst_wake;
    (st.state == smc_pkg::SMC_ASLEEP) && rst_s |=> st.by_reset;
  endproperty
  a_rst_wake: assert property (p_rst_wake)
    else $error("reset wake not recorded");

  property p_rst_exit;
    (st.state == smc_pkg::SMC_HOLD) && cnt_done && (st.by_reset || rst_s)
    |=> o_core_restart && !o_irq_resume;
  endproperty
  a_rst_exit: assert property (p_rst_exit)
    else $error("reset wake did not restart");

  // the wake is too long for a delay range, so a counter bounds it
  property p_wake_age;
    st.wake_age <= AGE_MAX;
  endproperty
  a_wake_age: assert property (p_wake_age)
    else $error("wake-up took too long");

  property p_stby;
    (st.state == smc_pkg::SMC_ASLEEP) && (rst_s || wake) &&
    (st.mode_lat == smc_pkg::SMC_STBY) |=> s_stby6;
  endproperty
  a_stby: assert property (p_stby)
    else $error("standby wake not six cycles");

  property p_idle;
    (st.state == smc_pkg::SMC_ASLEEP) && (st.mode_lat == smc_pkg::SMC_IDLE)
    |-> !o_core_clk_en && !o_prog_mem_clk_en && o_io_clk_en && o_hs_clk_en;
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle gating wrong");

  property p_pdown;
    (st.state == smc_pkg::SMC_ASLEEP) && (st.mode_lat == smc_pkg::SMC_PDOWN)
    |-> !o_main_osc_en && !o_io_clk_en && !o_timer_osc_en;
  endproperty
  a_pdown: assert property (p_pdown)
    else $error("power-down clocks running");

  property p_psave;
    (st.state == smc_pkg::SMC_ASLEEP) && (st.mode_lat == smc_pkg::SMC_PSAVE)
    && $stable(i_t2_async) |-> o_timer_osc_en == i_t2_async;
  endproperty
  a_psave: assert property (p_psave)
    else $error("timer oscillator wrong in power-save");

  property p_gate;
    wr && (idx == `SMC_IDX_GATE0) && i_pwdata[1] |=>
    ##1 o_periph_lock[1] && !o_periph_clk_en[1];
  endproperty
  a_gate: assert property (p_gate)
    else $error("peripheral clock not stopped");

  property p_reserved;
    (st.state == smc_pkg::SMC_RUN) && i_sleep_instr && !legal
    |=> st.state == smc_pkg::SMC_RUN;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved mode entered sleep");
endmodule // smc_ctrl

// [hw/smc_pkg.sv]
// types shared by the sleep mode controller
package smc_pkg;
  typedef enum logic [1:0] {
    SMC_RUN    = 2'h0,
    SMC_ASLEEP = 2'h1,
    SMC_START  = 2'h3,
    SMC_HOLD   = 2'h2
  } smc_state_t;
  typedef enum logic [2:0] {
    SMC_IDLE  = 3'h0,
    SMC_PDOWN = 3'h2,
    SMC_PSAVE = 3'h3,
    SMC_STBY  = 3'h6,
    SMC_XSTBY = 3'h7
  } smc_mode_t;
endpackage

// [hw/smc_regs.svh]
// register indices, field positions, reset values and timing counts
`ifndef SMC_REGS_SVH
`define SMC_REGS_SVH
`define SMC_IDX_CTRL      8'h33
`define SMC_IDX_GATE0     8'h64
`define SMC_IDX_GATE1     8'h65
`define SMC_IDX_STATUS    8'h66
`define SMC_CTRL_SE_BIT   0
`define SMC_CTRL_MODE_LSB 1
`define SMC_CTRL_MODE_MSB 3
`define SMC_CTRL_RST      4'h0
`define SMC_GATE_RST      8'h00
`define SMC_GATE0_MASK    8'hee
`define SMC_GATE1_MASK    8'h3f
`define SMC_HOLD_CYC      20'h00004
`define SMC_STBY_CYC      20'h00006
`define SMC_CNT_W         20
`endif

// [hw/smc_sync.sv]
// two flip-flop synchroniser for asynchronous wake inputs
module smc_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_nrst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } smc_sync_st_t;

  smc_sync_st_t st;
  smc_sync_st_t next_st;

  always_comb begin
    next_st.s1 = i_async;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_sync = st.s2;
endmodule // smc_sync

// [hw/smc_wake_cnt.sv]
// down counter timing start-up and hold phases; done in the last cycle
module smc_wake_cnt #(
  parameter int W = 20
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_nrst,
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_count,
  output logic              o_done
);
  typedef struct packed {
    logic         busy;
    logic [W-1:0] cnt;
  } smc_cnt_st_t;

  smc_cnt_st_t st;
  smc_cnt_st_t next_st;

  // a load of n gives done in the n-th cycle after the load edge
  always_comb begin
    next_st = st;
    if (i_load) begin
      next_st.busy = 1'b1;
      next_st.cnt  = i_count;
    end else if (st.busy) begin
      next_st.cnt = st.cnt - W'(1);
      if (st.cnt == W'(1)) begin
        next_st.busy = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_done = st.busy && (st.cnt == W'(1));
endmodule // smc_wake_cnt

// [test/sleep_mode_controller_bench.sv]
// self-checking bench for the sleep mode controller
module sleep_mode_controller_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [19:0] TS = 20'h00010;
  localparam logic [19:0] TL = 20'h00020;
  logic clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, r;
  logic pready, pslverr, er, sinstr, mwb, resume, restart, sleeping;
  logic sreq = 0, preq = 0, gie = 0, t2a = 0, t2r = 0, xrst = 0;
  logic [1:0] mask = 0;
  logic [3:0] fuses = 0, pins_n;
  logic [9:0] wk = 0;
  logic [7:0] en, g0, g1, e;
  logic [15:0] pce, plk;
  int bad_count = 0, num_checks = 0, cyc = 0, n;
  integer seed = 32'hcb3178af;
  smc_pkg::smc_mode_t md[5] = '{smc_pkg::SMC_IDLE, smc_pkg::SMC_PDOWN,
    smc_pkg::SMC_PSAVE, smc_pkg::SMC_STBY, smc_pkg::SMC_XSTBY};
  smc_pkg::smc_mode_t m;
  always #2.5 clk = ~clk;
  smc_core_model core (.i_clk_sys(clk), .i_nrst(nrst), .i_sleep_req(sreq),
    .i_pin_req(preq), .i_sleeping(sleeping), .o_sleep_instr(sinstr),
    .o_ext_irq_pins_n(pins_n));
  smc_ctrl #(.TOUT_SHORT(TS), .TOUT_LONG(TL)) dut (.i_clk_sys(clk),
    .i_nrst(nrst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_sleep_instr(sinstr),
    .i_gie(gie), .i_timer2_irq_mask(mask), .i_t2_async(t2a),
    .i_t2_running(t2r), .i_clock_source_fuses(fuses),
    .i_ext_irq_en(4'hf), .i_ext_irq_flag({3'h0, wk[9]}),
    .i_ext_irq_pins_n(pins_n),
    .i_wake_comm(wk[0]), .i_wake_card(wk[1]), .i_wake_pcint(wk[2]),
    .i_wake_kbd(wk[3]), .i_wake_wdt(wk[4]), .i_wake_t2_ovf(wk[5]),
    .i_wake_t2_cmp(wk[6]), .i_wake_spm_ee(wk[7]), .i_wake_other(wk[8]),
    .i_ext_reset(xrst), .o_core_clk_en(en[7]), .o_prog_mem_clk_en(en[6]),
    .o_io_clk_en(en[5]), .o_hs_clk_en(en[4]), .o_async_clk_en(en[3]),
    .o_main_osc_en(en[2]), .o_timer_osc_en(en[1]),
    .o_t2_sync_clk_en(en[0]), .o_periph_clk_en(pce), .o_periph_lock(plk),
    .o_mem_write_block(mwb), .o_irq_resume(resume),
    .o_core_restart(restart), .o_sleeping(sleeping));
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // hang guard, far above the few thousand cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      bad_count++;
      end_of_test;
    end
  end
  task automatic chk(input logic ok, input string s);
    num_checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("CHECK FAILED %0t %s", $time, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    // no wait limit here: the hang guard ends a stuck transfer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    pen <= 0;
    @(posedge clk);
  endtask
  task automatic enter(input logic [3:0] c);
    apb(1, 12'h0cc, {28'h0, c});
    sreq <= 1;
    @(posedge clk);
    sreq <= 0;
    repeat (6) @(posedge clk);
  endtask
  task automatic wake_pin;
    preq <= 1;
    @(posedge clk);
    preq <= 0;
    n = 0;
    while (resume !== 1'b1 && n < 60) begin
      @(posedge clk);
      n++;
    end
  endtask
  // enables {core,mem,io,hs,asy,osc,tosc,t2s} while asleep
  function automatic logic [7:0] en_exp(logic [2:0] c, logic a, logic u);
    logic s;
    s = ~a & u;
    case (c)
      3'h0: return {2'b00, 4'hf, a, 1'b1};
      3'h2: return 8'h00;
      3'h3: return {4'h0, 1'b1, s, a, s};
      3'h6: return 8'h04;
      default: return {4'h0, a, 1'b1, a, s};
    endcase
  endfunction
  function automatic int dly(logic [2:0] c);
    if (c == 3'h0) return 0;
    if (c[2]) return 6;
    return fuses[0] ? int'(TL) : int'(TS);
  endfunction
  // wake source order: comm card pcint kbd wdt t2ovf t2cmp spm other flag
  function automatic logic wakes(logic [2:0] c, int i);
    if (i < 5) return 1'b1;
    if (i < 7) return c != 3'h2 && gie && mask[i-5];
    return c == 3'h0;
  endfunction
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1;
    @(posedge clk);
    chk({en, pce, plk, mwb} === {8'hfd, 16'hffff, 16'h0, 1'b0}, "reset");
    apb(0, 12'h0cc, 0);
    chk(rd === 32'h0, "ctrl reset");
    chk(er === 1'b0, "ctrl error");
    apb(0, 12'h0f0, 0);
    chk(er === 1'b1 && rd === 32'h0, "unmapped");
    apb(1, 12'h0cc, 32'hffffffff);
    apb(0, 12'h0cc, 0);
    chk(rd === 32'hf, "ctrl bits");
    // the three reserved codes first, then enable clear
    foreach (g0[i]) if (i < 4) begin
      enter(i == 0 ? 4'he : {3'(i == 1 ? 1 : i + 2), 1'b1});
      chk(sleeping === 1'b0, "sleep refused");
    end
    for (int i = 0; i < 5; i++) begin
      m = md[i];
      t2a <= 1'($random(seed));
      t2r <= (m == smc_pkg::SMC_PSAVE) | 1'($random(seed));
      fuses <= 4'($random(seed));
      enter({m, 1'b1});
      e = en_exp(m, t2a, t2r);
      chk(en === e, "mode");
      chk({mwb, sleeping} === 2'b11, "asleep");
      wake_pin;
      chk(n === 8 + dly(m), "wake delay");
      chk({en[7:6], mwb} === 3'b110, "resumed");
    end
    for (int j = 0; j < 3; j++) for (int i = 0; i < 10; i++) begin
      gie <= 1'($random(seed));
      mask <= 2'($random(seed));
      enter({md[j], 1'b1});
      wk[i] <= 1'b1;
      repeat (50) @(posedge clk);
      chk(sleeping === !wakes(md[j], i), "wake source");
      wk <= 0;
      if (sleeping) wake_pin;
    end
    enter({3'h6, 1'b1});
    xrst <= 1;
    n = 0;
    while (restart !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk(restart === 1'b1 && resume === 1'b0, "reset wake");
    xrst <= 0;
    apb(0, 12'h198, 0);
    chk(rd === 32'h38, "status");
    for (int k = 0; k < 4; k++) begin
      r = k == 3 ? 32'h0 : $random(seed);
      g0 = r[7:0] & 8'hee;
      g1 = r[15:8] & 8'h3f;
      // no peripheral is active on this bench when its clock stops
      apb(1, 12'h190, r);
      apb(1, 12'h194, {24'h0, r[15:8]});
      apb(0, 12'h190, 0);
      chk(rd === {24'h0, g0}, "gate0");
      apb(0, 12'h194, 0);
      chk(rd === {24'h0, g1}, "gate1");
      chk({pce, plk} === {~{g1, g0}, g1, g0}, "gating");
    end
    end_of_test;
  end
endmodule // sleep_mode_controller_bench

// [test/smc_core_model.sv]
// cpu core and wake pin model facing the sleep controller
module smc_core_model (
  input  wire logic       i_clk_sys,
  input  wire logic       i_nrst,
  input  wire logic       i_sleep_req,
  input  wire logic       i_pin_req,
  input  wire logic       i_sleeping,
  output logic            o_sleep_instr,
  output logic      [3:0] o_ext_irq_pins_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hold;
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_sleep_instr <= 1'b0;
      hold <= 1'b0;
    end else begin
      // one executed opcode, so a single cycle wide
      o_sleep_instr <= i_sleep_req;
      // level kept until the core runs, so a one-cycle pulse still wakes it
      hold <= i_pin_req | (hold & i_sleeping);
    end
  end
  // released pins float to the pull-up level
  assign o_ext_irq_pins_n = {3'b111, ~hold};
endmodule // smc_core_model
